// File: rtl/sxc_pkg.sv
// Purpose: constants and types for the extended configuration, test result
//          and shutter register block of the motion sensor
// Assumes: 8-bit register port, single 125 MHz clock
// Notes:   byte offsets of the register port are the documented addresses
package sxc_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] CFG_ADDR     = 8'h0a;
  localparam logic [7:0] EXT_CFG_ADDR = 8'h0b;
  localparam logic [7:0] RES_LO_ADDR  = 8'h0c;
  localparam logic [7:0] RES_HI_ADDR  = 8'h0d;
  localparam logic [7:0] SHUT_LO_ADDR = 8'h0e;
  localparam logic [7:0] SHUT_HI_ADDR = 8'h0f;
  localparam logic [7:0] FWS_CMD_ADDR = 8'h14;
  localparam logic [7:0] FP_MAX_LO    = 8'h1a;
  localparam logic [7:0] FP_MAX_HI    = 8'h1b;
  localparam logic [7:0] SH_MAX_LO    = 8'h1e;
  localparam logic [7:0] SH_MAX_HI    = 8'h1f;

  // ***************************************************************
  // field positions and values
  // ***************************************************************
  localparam int         EXT_BUSY_BIT = 7;
  localparam int         EXT_ONE_BIT  = 3;
  localparam int         EXT_NPU_BIT  = 2;
  localparam int         EXT_EXPOSURE_CONTROL_DISABLE_BIT = 1;
  localparam int         EXT_FFR_BIT  = 0;
  localparam int         CFG_SYS_BIT  = 5;
  localparam logic [7:0] FWS_CMD_CRC  = 8'ha1;
  localparam logic [15:0] SHUTTER_RST = 16'h0085;
  localparam logic [15:0] FP_MAX_RST  = 16'h2ee0;
  localparam logic [15:0] SH_MAX_RST  = 16'h2000;
  localparam logic [15:0] SYS_PASS    = 16'ha9d5;
  localparam logic [15:0] SYS_FAIL    = 16'h0000;
  localparam logic [15:0] CRC_SEED    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [1:0]  BUSY_FRAMES = 2'h2;
  localparam int          SHUT_SHIFT  = 4;
  localparam int          STORE_AW    = 10;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_KHZ      = 125000;
  localparam int SYS_TEST_MS  = 200;
  localparam int CRC_WAIT_MS  = 7;
  localparam int SYS_TEST_CYC = SYS_TEST_MS * CLK_KHZ;
  localparam int CRC_WAIT_CYC = CRC_WAIT_MS * CLK_KHZ;
  localparam int WAIT_W       = 25;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    SXC_IDLE, SXC_SYS_RUN, SXC_CRC_READ, SXC_CRC_TIME, SXC_CRC_FRAME
  } sxc_phase_type;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] shutter;
  } sxc_expo_type;

  typedef struct packed {
    logic                npu;
    logic                exposure_control_disable;
    logic                ffr;
    logic [1:0]          busy_cnt;
    logic [15:0]         fp_max;
    logic [15:0]         sh_max;
    logic [15:0]         shutter;
    logic [15:0]         result;
    logic [15:0]         crc;
    logic [15:0]         frame_cnt;
    logic                frame_tick;
    sxc_phase_type       phase;
    logic [WAIT_W-1:0]   wait_cnt;
    logic [STORE_AW-1:0] addr;
    logic                data_ok;
    logic                wipe;
    logic [7:0]          rdata;
  } sxc_state_type;

endpackage

// File: rtl/sxc_regs.sv
// Purpose: extended configuration, self test results and shutter value
// Assumes: register port on i_clk; all other inputs from logic on i_clk
// Notes:   writes are ignored while a self test runs
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sxc_regs #(
  parameter int SYS_CYC = sxc_pkg::SYS_TEST_CYC,
  parameter int CRC_CYC = sxc_pkg::CRC_WAIT_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic [7:0]                    i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_we,
  input  wire logic                          i_re,
  output logic [7:0]                         o_rdata,
  input  wire logic [15:0]                   i_auto_period,
  input  wire logic                          i_expo_raise,
  input  wire logic                          i_expo_lower,
  input  wire logic                          i_self_test_ok,
  input  wire logic [7:0]                    i_store_data,
  output logic [sxc_pkg::STORE_AW-1:0]       o_store_addr,
  output logic                               o_store_wipe,
  output logic [2:0]                         o_pullup_en,
  output logic                               o_exposure_control_disable,
  output logic                               o_fixed_frame_rate,
  output sxc_pkg::sxc_expo_type              o_expo,
  output logic                               o_frame_tick,
  output logic                               o_nav_halt
);
  import sxc_pkg::*;

  sxc_state_type s_r;
  sxc_state_type s_nxt;
  logic [15:0]   period;
  logic          tick;
  logic          busy;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic is_ro(input logic [7:0] a);
    is_ro = (a == RES_LO_ADDR) || (a == RES_HI_ADDR) ||
            (a == SHUT_LO_ADDR) || (a == SHUT_HI_ADDR);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    crc_byte = x;
  endfunction

  assign period = s_r.ffr ? s_r.fp_max : i_auto_period;
  assign tick   = (17'({1'b0, s_r.frame_cnt}) + 17'h00001) >= {1'b0, period};
  assign busy   = (s_r.busy_cnt != 2'h0);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    logic [16:0] step;
    logic [16:0] up;
    logic [16:0] dn;
    step = {5'h00, s_r.shutter[15:SHUT_SHIFT]};
    if (step == 17'h00000)
    begin
      step = 17'h00001;
    end
    up = {1'b0, s_r.shutter} + step;
    dn = {1'b0, s_r.shutter} - step;
    s_nxt = s_r;
    s_nxt.frame_tick = tick;
    s_nxt.frame_cnt  = tick ? 16'h0000 : s_r.frame_cnt + 16'h0001;
    s_nxt.wipe    = 1'b0;
    s_nxt.data_ok = 1'b0;
    s_nxt.rdata   = 8'h00;
    // settling count runs down by frames
    if (tick && busy)
    begin
      s_nxt.busy_cnt = s_r.busy_cnt - 2'h1;
    end
    if (tick && s_r.phase == SXC_IDLE)
    begin
      if (s_r.exposure_control_disable)
      begin
        s_nxt.shutter = s_r.sh_max;
      end
      else if (i_expo_raise && !i_expo_lower)
      begin
        s_nxt.shutter = (up > {1'b0, s_r.sh_max}) ? s_r.sh_max : up[15:0];
      end
      else if (i_expo_lower && !i_expo_raise && dn != 17'h00000)
      begin
        s_nxt.shutter = dn[15:0];
      end
    end
    // read data one cycle later, either byte order
    if (i_re)
    begin
      case (i_addr)
        EXT_CFG_ADDR:
        begin
          s_nxt.rdata = 8'h00;
          s_nxt.rdata[EXT_BUSY_BIT] = busy;
          s_nxt.rdata[EXT_ONE_BIT]  = 1'b1;
          s_nxt.rdata[EXT_NPU_BIT]  = s_r.npu;
          s_nxt.rdata[EXT_EXPOSURE_CONTROL_DISABLE_BIT] = s_r.exposure_control_disable;
          s_nxt.rdata[EXT_FFR_BIT]  = s_r.ffr;
        end
        RES_LO_ADDR:  s_nxt.rdata = s_r.result[7:0];
        RES_HI_ADDR:  s_nxt.rdata = s_r.result[15:8];
        SHUT_LO_ADDR: s_nxt.rdata = s_r.shutter[7:0];
        SHUT_HI_ADDR: s_nxt.rdata = s_r.shutter[15:8];
        FP_MAX_LO:    s_nxt.rdata = s_r.fp_max[7:0];
        FP_MAX_HI:    s_nxt.rdata = s_r.fp_max[15:8];
        SH_MAX_LO:    s_nxt.rdata = s_r.sh_max[7:0];
        SH_MAX_HI:    s_nxt.rdata = s_r.sh_max[15:8];
        default:      s_nxt.rdata = 8'h00;
      endcase
    end
    // read-only offsets fall to default and change nothing
    if (i_we && s_r.phase == SXC_IDLE)
    begin
      case (i_addr)
        EXT_CFG_ADDR:
        begin
          s_nxt.npu  = i_wdata[EXT_NPU_BIT];
          s_nxt.exposure_control_disable = i_wdata[EXT_EXPOSURE_CONTROL_DISABLE_BIT];
          s_nxt.ffr  = i_wdata[EXT_FFR_BIT];
        end
        FP_MAX_LO: s_nxt.fp_max[7:0] = i_wdata;
        FP_MAX_HI:
        begin
          s_nxt.fp_max[15:8] = i_wdata;
          // upper bound write raises busy for two frames
          s_nxt.busy_cnt = BUSY_FRAMES;
        end
        SH_MAX_LO: s_nxt.sh_max[7:0]  = i_wdata;
        SH_MAX_HI: s_nxt.sh_max[15:8] = i_wdata;
        FWS_CMD_ADDR:
        begin
          if (i_wdata == FWS_CMD_CRC)
          begin
            s_nxt.phase    = SXC_CRC_READ;
            s_nxt.crc      = CRC_SEED;
            s_nxt.addr     = '0;
            s_nxt.wait_cnt = '0;
          end
        end
        CFG_ADDR:
        begin
          if (i_wdata[CFG_SYS_BIT])
          begin
            s_nxt.phase    = SXC_SYS_RUN;
            s_nxt.wait_cnt = '0;
          end
        end
        default: s_nxt.busy_cnt = s_nxt.busy_cnt;
      endcase
    end
    // ***************************************************************
    // self tests
    // ***************************************************************
    case (s_r.phase)
      SXC_SYS_RUN:
      begin
        s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
        if (s_r.wait_cnt == WAIT_W'(SYS_CYC - 1))
        begin
          s_nxt.result   = i_self_test_ok ? SYS_PASS : SYS_FAIL;
          s_nxt.phase    = SXC_IDLE;
          s_nxt.wipe     = 1'b1;
          s_nxt.npu      = 1'b0;
          s_nxt.exposure_control_disable     = 1'b0;
          s_nxt.ffr      = 1'b0;
          s_nxt.busy_cnt = 2'h0;
          s_nxt.fp_max   = FP_MAX_RST;
          s_nxt.sh_max   = SH_MAX_RST;
          s_nxt.shutter  = SHUTTER_RST;
        end
      end
      SXC_CRC_READ:
      begin
        s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
        s_nxt.addr     = s_r.addr + 1'b1;
        s_nxt.data_ok  = 1'b1;
        if (s_r.data_ok)
        begin
          s_nxt.crc = crc_byte(s_r.crc, i_store_data);
        end
        if (s_r.addr == {STORE_AW{1'b1}})
        begin
          s_nxt.phase = SXC_CRC_TIME;
        end
      end
      SXC_CRC_TIME:
      begin
        if (s_r.data_ok)
        begin
          s_nxt.crc = crc_byte(s_r.crc, i_store_data);
        end
        // 7 ms before the frame wait
        s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
        if (s_r.wait_cnt >= WAIT_W'(CRC_CYC - 1))
        begin
          s_nxt.phase = SXC_CRC_FRAME;
        end
      end
      SXC_CRC_FRAME:
      begin
        if (tick)
        begin
          s_nxt.result = s_r.crc;
          s_nxt.phase  = SXC_IDLE;
        end
      end
      default: s_nxt.phase = s_nxt.phase;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r         <= '0;
      s_r.phase   <= SXC_IDLE;
      s_r.fp_max  <= FP_MAX_RST;
      s_r.sh_max  <= SH_MAX_RST;
      s_r.shutter <= SHUTTER_RST;
      s_r.crc     <= CRC_SEED;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign o_rdata                    = s_r.rdata;
  assign o_store_addr               = s_r.addr;
  assign o_store_wipe               = s_r.wipe;
  assign o_pullup_en                = {3{~s_r.npu}};
  assign o_exposure_control_disable = s_r.exposure_control_disable;
  // fixed rate uses the upper bound
  assign o_fixed_frame_rate         = s_r.ffr;
  assign o_expo.period              = period;
  assign o_expo.shutter             = s_r.shutter;
  assign o_frame_tick               = s_r.frame_tick;
  assign o_nav_halt                 = (s_r.phase != SXC_IDLE);

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_crc_cmd;
    i_we && i_addr == FWS_CMD_ADDR && i_wdata == FWS_CMD_CRC && s_r.phase == SXC_IDLE;
  endsequence
  sequence s_halt_read;
    o_nav_halt && s_r.phase == SXC_CRC_READ && s_r.addr == '0;
  endsequence
  sequence s_sys_end;
    s_r.phase == SXC_SYS_RUN && s_r.wait_cnt == WAIT_W'(SYS_CYC - 1);
  endsequence

  busy_raise_a: assert property (
    i_we && i_addr == FP_MAX_HI && s_r.phase == SXC_IDLE |=> busy [*2])
    else $error("busy not raised after bound write");
  busy_hold_a: assert property (
    busy && !tick && !s_nxt.wipe |=> busy)
    else $error("busy dropped before frame");
  pullup_ctl_a: assert property (
    i_we && i_addr == EXT_CFG_ADDR && s_r.phase == SXC_IDLE
      |=> o_pullup_en == {3{~$past(i_wdata[EXT_NPU_BIT])}})
    else $error("pull-up enable wrong");
  agc_fix_a: assert property (
    tick && s_r.exposure_control_disable && s_r.phase == SXC_IDLE |=> o_expo.shutter == $past(s_r.sh_max))
    else $error("shutter not fixed to bound");
  fixed_rate_a: assert property (
    s_r.ffr |-> o_expo.period == s_r.fp_max)
    else $error("fixed period not from bound");
  res_read_a: assert property (
    i_re && i_addr == RES_HI_ADDR |=> o_rdata == $past(s_r.result[15:8]))
    else $error("result high byte read wrong");
  sys_pass_a: assert property (
    s_sys_end and i_self_test_ok |=> s_r.result == SYS_PASS && o_store_wipe ##1 !o_store_wipe)
    else $error("system test pass value wrong");
  crc_start_a: assert property (
    s_crc_cmd |=> s_halt_read)
    else $error("checksum test did not start");
  ro_write_a: assert property (
    i_we && is_ro(i_addr) && s_r.phase == SXC_IDLE && !tick |=> $stable(o_expo.shutter)
      && $stable(s_r.result))
    else $error("read-only register changed by write");
  agc_up_a: assert property (
    tick && !s_r.exposure_control_disable && s_r.phase == SXC_IDLE && i_expo_raise && !i_expo_lower
      && s_r.shutter < 16'h0f00 && s_r.shutter >= 16'h0010 && s_r.sh_max >= 16'h1000
      |=> o_expo.shutter == $past(s_r.shutter) + ($past(s_r.shutter) >> 4))
    else $error("exposure step not one sixteenth");

endmodule
`default_nettype wire

// File: sim/sxc_store_model.sv
// Purpose: firmware store model on the far side of the checksum reader
// Assumes: same clock as the register block
// Notes:   byte i holds i xor 0x5a until a wipe clears the whole store
`timescale 1ns/10ps
`default_nettype none
module sxc_store_model (
  input  wire logic                         i_clk,
  input  wire logic [sxc_pkg::STORE_AW-1:0] i_addr,
  input  wire logic                         i_wipe,
  output logic [7:0]                        o_data
);
  import sxc_pkg::*;
  logic [7:0] mem [0:(1<<STORE_AW)-1];

  initial
  begin
    for (int i = 0; i < (1 << STORE_AW); i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end

  // one cycle read latency, wipe clears all bytes
  always @(posedge i_clk)
  begin
    if (i_wipe)
      for (int i = 0; i < (1 << STORE_AW); i++)
        mem[i] <= 8'h00;
    o_data <= mem[i_addr];
  end
endmodule
`default_nettype wire

// File: sim/sxc_regs_bench.sv
// Purpose: self-checking bench for the extended configuration block
// Assumes: 125 MHz clock, shortened self test lengths
// Notes:   the bench acts as the controller on the register port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module sxc_regs_bench;
  import sxc_pkg::*;
  localparam int SYS_C = 200;
  localparam int CRC_C = 1100;
  logic                i_clk = 1'b0;
  logic                i_rst = 1'b1;
  logic [7:0]          i_addr = 8'h00;
  logic [7:0]          i_wdata = 8'h00;
  logic                i_we = 1'b0;
  logic                i_re = 1'b0;
  logic [15:0]         i_auto_period = 16'h0020;
  logic                i_expo_raise = 1'b0;
  logic                i_expo_lower = 1'b0;
  logic                i_self_test_ok = 1'b1;
  logic [7:0]          o_rdata;
  logic [7:0]          store_data;
  logic [STORE_AW-1:0] store_addr;
  logic                store_wipe;
  logic [2:0]          o_pullup_en;
  logic                o_exposure_control_disable;
  logic                o_fixed_frame_rate;
  sxc_expo_type        o_expo;
  logic                o_frame_tick;
  logic                o_nav_halt;
  int                  failures = 0;
  int                  samples_checked = 0;

  always #4 i_clk = ~i_clk;

  sxc_regs #(.SYS_CYC(SYS_C), .CRC_CYC(CRC_C)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .i_auto_period(i_auto_period),
    .i_expo_raise(i_expo_raise), .i_expo_lower(i_expo_lower),
    .i_self_test_ok(i_self_test_ok), .i_store_data(store_data), .o_store_addr(store_addr),
    .o_store_wipe(store_wipe), .o_pullup_en(o_pullup_en),
    .o_exposure_control_disable(o_exposure_control_disable),
    .o_fixed_frame_rate(o_fixed_frame_rate), .o_expo(o_expo),
    .o_frame_tick(o_frame_tick), .o_nav_halt(o_nav_halt));

  sxc_store_model store_u (
    .i_clk(i_clk), .i_addr(store_addr), .i_wipe(store_wipe), .o_data(store_data));

  // ***************************************************************
  // port tasks
  // ***************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timeout(input string nm);
    failures++;
    $display("ERROR %s expected done seen timeout", nm);
    close_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_we    <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(posedge i_clk);
    i_addr <= a;
    i_re   <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    `CHK(nm, ex, o_rdata)
  endtask

  task automatic wait_tick();
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_frame_tick !== 1'b1 && n < 500)
    begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 500) timeout("frame tick");
  endtask

  task automatic wait_halt(output int n, output int w);
    n = 0;
    w = 0;
    @(negedge i_clk);
    `CHK("halt start", 1'b1, o_nav_halt)
    while (o_nav_halt === 1'b1 && n < 5000)
    begin
      @(negedge i_clk);
      n++;
      if (store_wipe === 1'b1) w++;
    end
    @(negedge i_clk);
    if (store_wipe === 1'b1) w++;
    if (n >= 5000) timeout("halt");
  endtask

  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 0; i < (1 << STORE_AW); i++)
    begin
      c = c ^ {8'(i) ^ 8'h5a, 8'h00};
      for (int b = 0; b < 8; b++)
        c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    rdc(EXT_CFG_ADDR, 8'h08, "ext config");
    rdc(SHUT_HI_ADDR, 8'h00, "shutter high");
    rdc(SHUT_LO_ADDR, 8'h85, "shutter low");
    rdc(8'h30, 8'h00, "unmapped");
    `CHK("pullups on", 3'b111, o_pullup_en)
    $display("test reset done");
  endtask

  task automatic t_cfg();
    wr(EXT_CFG_ADDR, 8'hff);
    rdc(EXT_CFG_ADDR, 8'h0f, "ext config all");
    `CHK("pullups off", 3'b000, o_pullup_en)
    `CHK("exposure off", 1'b1, o_exposure_control_disable)
    `CHK("fixed rate", 1'b1, o_fixed_frame_rate)
    `CHK("fixed period", FP_MAX_RST, o_expo.period)
    wr(EXT_CFG_ADDR, 8'h00);
    #1;
    `CHK("pullups back", 3'b111, o_pullup_en)
    `CHK("auto period", 16'h0020, o_expo.period)
    $display("test config done");
  endtask

  task automatic t_busy();
    wr(EXT_CFG_ADDR, 8'h01);
    wr(FP_MAX_LO, 8'h18);
    wr(FP_MAX_HI, 8'h00);
    rdc(EXT_CFG_ADDR, 8'h89, "busy set");
    `CHK("new period", 16'h0018, o_expo.period)
    // two frames pass before busy is read back clear
    wait_tick();
    wait_tick();
    rdc(EXT_CFG_ADDR, 8'h09, "busy clear");
    $display("test busy done");
  endtask

  task automatic t_agc();
    wait_tick();
    @(posedge i_clk) i_expo_raise <= 1'b1;
    wait_tick();
    @(posedge i_clk) i_expo_raise <= 1'b0;
    // high byte first, low byte right after
    rdc(SHUT_HI_ADDR, 8'h00, "raise high");
    rdc(SHUT_LO_ADDR, 8'h8d, "raise low");
    wait_tick();
    @(posedge i_clk) i_expo_lower <= 1'b1;
    wait_tick();
    @(posedge i_clk) i_expo_lower <= 1'b0;
    rdc(SHUT_LO_ADDR, 8'h85, "lower low");
    wr(SH_MAX_LO, 8'h40);
    wr(SH_MAX_HI, 8'h00);
    wr(EXT_CFG_ADDR, 8'h03);
    // a tick right at the write edge may predate the disable
    wait_tick();
    wait_tick();
    rdc(SHUT_LO_ADDR, 8'h40, "fixed shutter");
    `CHK("shutter port", 16'h0040, o_expo.shutter)
    wr(SHUT_LO_ADDR, 8'h12);
    rdc(SHUT_LO_ADDR, 8'h40, "shutter kept");
    $display("test exposure done");
  endtask

  task automatic t_crc();
    int n;
    int w;
    logic [15:0] c;
    c = crc_exp();
    wr(FWS_CMD_ADDR, FWS_CMD_CRC);
    wait_halt(n, w);
    `CHK("checksum wait", 1'b1, n >= CRC_C - 2)
    rdc(RES_LO_ADDR, c[7:0], "crc low");
    rdc(RES_HI_ADDR, c[15:8], "crc high");
    $display("test checksum done");
  endtask

  task automatic t_sys();
    int n;
    int w;
    // hardware reset right before the system test
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    wr(EXT_CFG_ADDR, 8'h07);
    wr(CFG_ADDR, 8'h28);
    wait_halt(n, w);
    `CHK("system wait", 1'b1, n >= SYS_C - 2)
    `CHK("wipe pulse", 1, w)
    rdc(RES_HI_ADDR, 8'ha9, "pass high");
    rdc(RES_LO_ADDR, 8'hd5, "pass low");
    rdc(EXT_CFG_ADDR, 8'h08, "settings lost");
    // failing hardware verdict leaves the fail code
    @(posedge i_clk);
    i_rst          <= 1'b1;
    i_self_test_ok <= 1'b0;
    @(posedge i_clk);
    i_rst <= 1'b0;
    wr(CFG_ADDR, 8'h28);
    wait_halt(n, w);
    `CHK("fail wipe pulse", 1, w)
    rdc(RES_HI_ADDR, SYS_FAIL[15:8], "fail high");
    rdc(RES_LO_ADDR, SYS_FAIL[7:0], "fail low");
    $display("test system done");
  endtask

  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_cfg();
    t_busy();
    t_agc();
    t_crc();
    t_sys();
    close_out();
  end
endmodule
`default_nettype wire
